//--- logic/ddrqr_read.sv
// device-side double-rate quad I/O read command path, serial link oversampled
`timescale 1ns/1ns
module ddrqr_read #(
   parameter int MEM_ADDR_W = 23
) (
   input wire logic clock,                            // system clock, 20 MHz
   input wire logic arst_n,                           // async reset, active low
   input wire logic cs_n,                             // chip select pin, active low
   input wire logic sck,                              // serial clock pin
   input wire logic [3:0] io_in,                      // I/O pin levels
   output logic [3:0] io_out,                         // I/O drive values
   output logic io_oe,                                // I/O drive enable, high drives
   input wire ddrqr_pkg::ddrqr_cfg_s cfg,             // configuration bits
   output logic [MEM_ADDR_W-1:0] mem_addr,            // array read address
   input wire logic [7:0] mem_rdata,                  // array byte at mem_addr
   output logic execute_in_place                      // continuous read active
);
   import ddrqr_pkg::*;

   logic [5:0] sync1_ff;
   logic [5:0] sync2_ff;
   logic sck_d_ff;
   logic cs_s;
   logic sck_s;
   logic [3:0] io_s;
   logic rise;
   logic fall;
   logic sck_edge;
   logic [4:0] dum_edges;

   ddrqr_state_e state_ff, nxt_state;
   logic [4:0] cnt_ff, nxt_cnt;
   logic [7:0] opc_ff, nxt_opc;
   logic [31:0] addr_ff, nxt_addr;
   logic [7:0] mode_ff, nxt_mode;
   logic addr4_ff, nxt_addr4;
   logic half_ff, nxt_half;
   logic cont_ff, nxt_cont;
   logic cont_pend_ff, nxt_cont_pend;
   logic [3:0] io_out_ff, nxt_io_out;
   logic io_oe_ff, nxt_io_oe;
   logic [MEM_ADDR_W-1:0] mem_addr_ff, nxt_mem_addr;

   // pins pass two stages; sck and io share stages so edges and data stay aligned
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sync1_ff <= 6'h3D;
         sync2_ff <= 6'h3D;
         sck_d_ff <= 1'b0;
      end else begin
         sync1_ff <= {cs_n, sck, io_in};
         sync2_ff <= sync1_ff;
         sck_d_ff <= sync2_ff[4];
      end
   end

   assign cs_s = sync2_ff[5];
   assign sck_s = sync2_ff[4];
   assign io_s = sync2_ff[3:0];
   assign rise = sck_s & ~sck_d_ff;
   assign fall = ~sck_s & sck_d_ff;
   assign sck_edge = rise | fall;
   assign dum_edges = {cfg.latency_code, 1'b0};

   // drive for the half cycle that precedes data by 'left' edges
   function automatic logic [5:0] launch(input logic [4:0] left, input ddrqr_cfg_s c,
                                         input logic [7:0] rd);
      logic [2:0] bit_idx;
      bit_idx = 3'(left - 5'h01);
      if (left == 5'h00)
         launch = {1'b1, 1'b1, rd[7:4]};
      else if (c.capture_training_pattern && left <= PREAMBLE_EDGES)
         launch = {1'b0, 1'b1, {4{c.training_pattern[bit_idx]}}};
      else
         launch = {1'b0, 1'b0, IO_OUT_RST};
   endfunction

   function automatic logic complementary(input logic [7:0] m);
      complementary = (m[7:4] == ~m[3:0]);
   endfunction

   always_comb begin
      logic [7:0] opc_new;
      logic [31:0] addr_new;
      logic [7:0] mode_new;
      logic [4:0] cnt_inc;
      logic [5:0] drv;
      opc_new = cfg.four_wire_command_select ? {opc_ff[3:0], io_s} : {opc_ff[6:0], io_s[0]};
      addr_new = {addr_ff[27:0], io_s};
      mode_new = {mode_ff[3:0], io_s};
      cnt_inc = cnt_ff + 5'h01;
      drv = 6'h00;
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_opc = opc_ff;
      nxt_addr = addr_ff;
      nxt_mode = mode_ff;
      nxt_addr4 = addr4_ff;
      nxt_half = half_ff;
      nxt_cont = cont_ff;
      nxt_cont_pend = cont_pend_ff;
      nxt_io_out = io_out_ff;
      nxt_io_oe = io_oe_ff;
      nxt_mem_addr = mem_addr_ff;
      if (cs_s) begin
         nxt_state = ST_IDLE;
         nxt_io_oe = 1'b0;
         if (state_ff != ST_IDLE) begin
            nxt_cont = cont_pend_ff;
            // opcode-less frame that carried only the mode reset byte
            if (state_ff == ST_ADDR && cont_ff && cnt_ff == 5'h02
                && addr_ff[7:0] == OPC_MODE_RESET) begin
               nxt_cont = 1'b0;
               nxt_cont_pend = 1'b0;
            end
         end
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               nxt_cnt = 5'h00;
               nxt_opc = 8'h00;
               nxt_addr = ADDR_RST;
               nxt_cont_pend = cont_ff;
               nxt_state = cont_ff ? ST_ADDR : ST_OPCODE;
            end
            ST_OPCODE: begin
               if (rise) begin
                  nxt_opc = opc_new;
                  nxt_cnt = cnt_inc;
                  if (cnt_inc == (cfg.four_wire_command_select ? QUAD_OPC_EDGES
                                                               : SDR_OPC_EDGES)) begin
                     nxt_cnt = 5'h00;
                     nxt_state = ST_IGNORE;
                     if ((opc_new == OPC_READ_SEL || opc_new == OPC_READ_4B)
                         && cfg.quad_enable) begin
                        nxt_state = ST_ADDR;
                        nxt_addr4 = (opc_new == OPC_READ_4B) | cfg.address_length_select;
                     end else if (opc_new == OPC_MODE_RESET) begin
                        nxt_cont = 1'b0;
                        nxt_cont_pend = 1'b0;
                     end
                  end
               end
            end
            ST_ADDR: begin
               // the address opens on a rising edge
               if (sck_edge && !(fall && cnt_ff == 5'h00)) begin
                  nxt_addr = addr_new;
                  nxt_cnt = cnt_inc;
                  if (cnt_inc == (addr4_ff ? ADDR4_EDGES : ADDR3_EDGES)) begin
                     nxt_cnt = 5'h00;
                     nxt_mem_addr = addr_new[MEM_ADDR_W-1:0];
                     nxt_state = ST_MODE;
                  end
               end
            end
            ST_MODE: begin
               if (sck_edge) begin
                  nxt_mode = mode_new;
                  nxt_cnt = cnt_inc;
                  if (cnt_inc == MODE_EDGES) begin
                     nxt_cnt = 5'h00;
                     nxt_cont_pend = complementary(mode_new);
                     drv = launch(dum_edges, cfg, mem_rdata);
                     nxt_half = drv[5];
                     nxt_io_oe = drv[4];
                     nxt_io_out = drv[3:0];
                     nxt_state = (dum_edges == 5'h00) ? ST_DATA : ST_DUMMY;
                  end
               end
            end
            ST_DUMMY: begin
               if (sck_edge) begin
                  nxt_cnt = cnt_inc;
                  drv = launch(5'(dum_edges - cnt_inc), cfg, mem_rdata);
                  nxt_half = drv[5];
                  nxt_io_oe = drv[4];
                  nxt_io_out = drv[3:0];
                  if (cnt_inc == dum_edges)
                     nxt_state = ST_DATA;
               end
            end
            ST_DATA: begin
               if (sck_edge) begin
                  nxt_io_oe = 1'b1;
                  if (half_ff) begin
                     nxt_io_out = mem_rdata[3:0];
                     nxt_half = 1'b0;
                     // natural roll-over of the counter gives the wrap to zero
                     nxt_mem_addr = mem_addr_ff + 1'b1;
                  end else begin
                     nxt_io_out = mem_rdata[7:4];
                     nxt_half = 1'b1;
                  end
               end
            end
            ST_IGNORE: begin
               nxt_io_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= ST_IDLE;
         cnt_ff <= 5'h00;
         opc_ff <= 8'h00;
         addr_ff <= ADDR_RST;
         mode_ff <= 8'h00;
         addr4_ff <= 1'b0;
         half_ff <= 1'b0;
         cont_ff <= 1'b0;
         cont_pend_ff <= 1'b0;
         io_out_ff <= IO_OUT_RST;
         io_oe_ff <= 1'b0;
         mem_addr_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         opc_ff <= nxt_opc;
         addr_ff <= nxt_addr;
         mode_ff <= nxt_mode;
         addr4_ff <= nxt_addr4;
         half_ff <= nxt_half;
         cont_ff <= nxt_cont;
         cont_pend_ff <= nxt_cont_pend;
         io_out_ff <= nxt_io_out;
         io_oe_ff <= nxt_io_oe;
         mem_addr_ff <= nxt_mem_addr;
      end
   end

   assign io_out = io_out_ff;
   assign io_oe = io_oe_ff;
   assign mem_addr = mem_addr_ff;
   assign execute_in_place = cont_ff;

   // helper: edges seen in the dummy phase
   logic [4:0] dmy_h_ff;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         dmy_h_ff <= 5'h00;
      else if (state_ff == ST_MODE)
         dmy_h_ff <= 5'h00;
      else if (state_ff == ST_DUMMY && sck_edge && !cs_s)
         dmy_h_ff <= dmy_h_ff + 5'h01;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);

   a_release_on_deselect: assert property (cs_s |=> !io_oe_ff)
      else $error("I/O still driven after deselect");
   a_host_phase_quiet: assert property (
      state_ff inside {ST_OPCODE, ST_ADDR, ST_MODE, ST_IGNORE} |-> !io_oe_ff)
      else $error("I/O driven during host phase");
   a_quad_gate: assert property (
      (state_ff == ST_OPCODE && nxt_state == ST_ADDR) |-> cfg.quad_enable)
      else $error("read accepted without quad enable");
   a_addr_length: assert property (
      (state_ff == ST_OPCODE && nxt_state == ST_ADDR)
      |=> addr4_ff == (opc_ff == OPC_READ_4B || $past(cfg.address_length_select)))
      else $error("wrong address length chosen");
   a_dummy_count: assert property (
      ($rose(state_ff == ST_DATA) && !cs_s) |-> dmy_h_ff == dum_edges)
      else $error("dummy edge count differs from latency");
   a_preamble_same: assert property (
      (state_ff == ST_DUMMY && io_oe_ff) |->
      cfg.capture_training_pattern && (&io_out_ff || ~|io_out_ff))
      else $error("preamble not uniform on all lines");
   a_data_driven: assert property (
      (state_ff == ST_DATA && !cs_s) |-> io_oe_ff)
      else $error("data phase without drive");
   a_addr_advance: assert property (
      (state_ff == ST_DATA && sck_edge && half_ff && !cs_s)
      |=> mem_addr_ff == MEM_ADDR_W'($past(mem_addr_ff) + 1'b1))
      else $error("address did not advance after byte");
   a_cont_update: assert property (
      (cs_s && state_ff == ST_DATA) |=> cont_ff == $past(cont_pend_ff))
      else $error("continuous mode not updated at deselect");
endmodule

//--- logic/ddrqr_pkg.sv
// shared constants and types for the double-rate quad read path
package ddrqr_pkg;
   // opcodes of the double-rate quad read and the mode reset
   localparam logic [7:0] OPC_READ_SEL = 8'hED;
   localparam logic [7:0] OPC_READ_4B = 8'hEE;
   localparam logic [7:0] OPC_MODE_RESET = 8'hFF;
   // serial clock edges per phase
   localparam logic [4:0] SDR_OPC_EDGES = 5'h08;
   localparam logic [4:0] QUAD_OPC_EDGES = 5'h02;
   localparam logic [4:0] ADDR3_EDGES = 5'h06;
   localparam logic [4:0] ADDR4_EDGES = 5'h08;
   localparam logic [4:0] MODE_EDGES = 5'h02;
   localparam logic [4:0] PREAMBLE_EDGES = 5'h08;
   // synchroniser depth for pin inputs
   localparam int SYNC_STAGES = 2;
   // reset values
   localparam logic [3:0] IO_OUT_RST = 4'h0;
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;

   typedef struct packed {
      logic quad_enable;                 // volatile_config_one quad enable bit
      logic address_length_select;       // 4-byte address for the select opcode
      logic four_wire_command_select;    // four_wire_command_mode opcode transfer
      logic capture_training_pattern;    // preamble enable
      logic [3:0] latency_code;          // dummy clock cycles
      logic [7:0] training_pattern;      // preamble byte
   } ddrqr_cfg_s;

   typedef enum logic [2:0] {
      ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGNORE
   } ddrqr_state_e;
endpackage

//--- verification/ddrqr_host_model.sv
// host controller model for the serial link of the quad read path
`timescale 1ns/1ns
module ddrqr_host_model (
   input wire logic clock, // system clock
   input wire logic [3:0] io_wire, // resolved I/O levels
   input wire logic dev_oe, // device drive enable
   output logic cs_n, // chip select, active low
   output logic sck, // serial clock, idles low
   output logic [3:0] h_drv, // host drive values
   output logic h_oe // host drive enable
);
   logic [3:0] seen_io;
   logic seen_oe;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      h_drv = 4'h0;
      h_oe = 1'b0;
   end
   // 400 ns period keeps the link far under its rated maximum
   task automatic clk_edge(input logic [3:0] v, input logic drv);
      repeat (2) @(negedge clock);
      h_oe = drv;
      if (drv)
         h_drv = v;
      repeat (2) @(negedge clock);
      // sampled just before the next edge, while the last launch still stands
      seen_io = io_wire;
      seen_oe = dev_oe;
      sck = ~sck;
   endtask
   task automatic begin_frame;
      cs_n = 1'b0;
      repeat (4) @(negedge clock);
   endtask
   task automatic end_frame;
      if (sck)
         clk_edge(4'h0, 1'b0);
      repeat (4) @(negedge clock);
      cs_n = 1'b1;
      h_oe = 1'b0;
      repeat (10) @(negedge clock);
   endtask
endmodule

//--- verification/test_ddr_quad_io_read.sv
// self-checking bench for the double-rate quad read path
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((e) !== (g)) begin err_total++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_ddr_quad_io_read;
   import ddrqr_pkg::*;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic cs_n, sck, io_oe, h_oe, execute_in_place;
   logic [3:0] io_in, io_out, h_drv;
   logic [22:0] mem_addr;
   logic [7:0] mem_rdata;
   ddrqr_cfg_s cfg;
   int err_total = 0;
   int samples_checked = 0;
   always #25 clock = ~clock;
   // undriven lines show the inverse of the last host value, never a held level
   assign io_in = io_oe ? io_out : (h_oe ? h_drv : ~h_drv);
   // top address bits folded in so a missed wrap reads differently
   assign mem_rdata = mem_addr[7:0] + mem_addr[22:15];
   ddrqr_read i_dut (.clock(clock), .arst_n(arst_n), .cs_n(cs_n), .sck(sck),
      .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .cfg(cfg), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .execute_in_place(execute_in_place));
   ddrqr_host_model i_host (.clock(clock), .io_wire(io_in), .dev_oe(io_oe),
      .cs_n(cs_n), .sck(sck), .h_drv(h_drv), .h_oe(h_oe));
   task automatic set_cfg(input logic q, s, w, p, input logic [3:0] l);
      @(negedge clock);
      cfg = '{q, s, w, p, l, 8'h34};
   endtask
   task automatic run(input bit op, input logic [7:0] opc, input int na,
      input logic [31:0] ad, input logic [7:0] md, input int nb, input bit ok,
      input logic xp);
      int lat, pre, l;
      logic [3:0] ex;
      logic eo;
      logic [22:0] a;
      logic [7:0] b;
      lat = int'(cfg.latency_code);
      pre = cfg.capture_training_pattern ? 8 : 0;
      i_host.begin_frame();
      for (int i = 0; op && i < (cfg.four_wire_command_select ? 4 : 16); i++)
         i_host.clk_edge(cfg.four_wire_command_select ? opc[7 - 4 * (i / 2) -: 4]
            : {3'h0, opc[7 - i / 2]}, 1'b1);
      for (int i = 0; i < na; i++)
         i_host.clk_edge(ad[4 * (na - 1 - i) +: 4], 1'b1);
      if (na > 2) begin
         i_host.clk_edge(md[7:4], 1'b1);
         i_host.clk_edge(md[3:0], 1'b1);
         for (int i = 0; i <= 2 * lat + 2 * nb; i++) begin
            i_host.clk_edge(4'h0, 1'b0);
            // l counts launches from the first data nibble
            l = i - 2 * lat;
            eo = ok && l >= -pre;
            a = ad[22:0] + 23'(l / 2);
            b = a[7:0] + a[22:15];
            ex = l[0] ? b[3:0] : b[7:4];
            if (l < 0 && pre > 0 && l >= -8)
               ex = {4{cfg.training_pattern[-1 - l]}};
            `CHK("io_oe", eo, i_host.seen_oe)
            if (eo)
               `CHK("io_data", ex, i_host.seen_io)
         end
      end
      i_host.end_frame();
      `CHK("xip", xp, execute_in_place)
   endtask
   task automatic t_basic;
      set_cfg(1, 0, 0, 0, 4'h2);
      run(1, OPC_READ_SEL, 6, 32'h0012_3456, 8'h00, 3, 1, 0);
   endtask
   task automatic t_wide;
      set_cfg(1, 1, 0, 0, 4'h0);
      run(1, OPC_READ_SEL, 8, 32'hFF7F_FFFE, 8'h00, 4, 1, 0);
      set_cfg(1, 0, 0, 0, 4'h3);
      run(1, OPC_READ_4B, 8, 32'h007F_FFFF, 8'h00, 2, 1, 0);
   endtask
   task automatic t_preamble;
      set_cfg(1, 0, 1, 1, 4'h6);
      run(1, OPC_READ_SEL, 6, 32'h0000_0010, 8'h00, 2, 1, 0);
   endtask
   task automatic t_refused;
      set_cfg(0, 0, 0, 0, 4'h2);
      run(1, OPC_READ_SEL, 6, 32'h0000_0100, 8'h00, 2, 0, 0);
      set_cfg(1, 0, 0, 0, 4'h2);
      run(1, 8'h0B, 6, 32'h0000_0100, 8'h00, 2, 0, 0);
   endtask
   task automatic t_xip;
      set_cfg(1, 0, 0, 0, 4'h2);
      run(1, OPC_READ_SEL, 6, 32'h0000_4000, 8'h5A, 2, 1, 1);
      run(0, 8'h00, 6, 32'h0040_0001, 8'hC3, 2, 1, 1);
      run(0, 8'h00, 6, 32'h0000_0002, 8'h12, 1, 1, 0);
      run(1, OPC_READ_SEL, 6, 32'h0000_0003, 8'hA5, 1, 1, 1);
      run(0, 8'h00, 2, 32'h0000_00FF, 8'h00, 0, 1, 0);
      run(1, OPC_READ_SEL, 6, 32'h0000_0004, 8'h00, 1, 1, 0);
   endtask
   task automatic end_of_test;
      $display("mismatches %0d, comparisons %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      cfg = '{1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 8'h00};
      repeat (12) @(negedge clock);
      arst_n = 1'b1;
      repeat (6) @(negedge clock);
      t_basic();
      t_wide();
      t_preamble();
      t_refused();
      t_xip();
      end_of_test();
   end
   initial begin
      // about twenty-five times the expected run time
      #2000000;
      err_total++;
      end_of_test();
   end
endmodule
